/* logic/exec_unit.sv */
// Summary of operation
// - rotate right through carry changes only carry; file index 0..127.
// - destination bit 0 writes accumulator, 1 writes the addressed file register.
// - sleep zeroes watchdog counter and prescaler, sets timeout, clears power-down.
// - after those updates the unit enters low power with oscillator stopped.
// - literal minus accumulator into accumulator, updating carry, half carry, zero.
// - file minus accumulator to chosen destination, updating carry, half carry, zero.
// - nibble exchange swaps halves to chosen destination, no flag changes.
// - accumulator xor literal into accumulator, only zero flag changes.
// - accumulator xor file to chosen destination, only zero flag changes.
`timescale 1ns/1ps
`default_nettype none
module exec_unit (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // instruction issue
  input wire logic issueValid,
  input wire exec_pkg::op_e issueOp,
  input wire logic [6:0] fileIdx,
  input wire logic destSel,
  input wire logic [7:0] literal,
  output logic issueDone,
  // register port
  input wire logic [7:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic busWr,
  input wire logic busRd,
  output logic [7:0] busRdData,
  // power state
  output logic oscEnable,
  output logic asleep
);
  typedef struct packed {
    logic [127:0][7:0] mem;
    logic [7:0] acc;
    logic [4:0] stat;
    exec_pkg::mode_e mode;
    logic [7:0] rdData;
    logic done;
    logic oscOn;
    logic sleeping;
  } exec_s;

  exec_s st_r;
  exec_s st_nxt;
  logic issueTake;
  logic sleepTake;
  logic [7:0] srcVal;
  logic [7:0] aluResult;
  logic aluC;
  logic aluDc;
  logic aluZ;
  logic updC;
  logic updDc;
  logic updZ;
  logic fileForm;
  logic [7:0] wdogCount;
  logic [7:0] prescCount;
  logic runCycle;

  // instructions are refused outside the run mode
  assign issueTake = issueValid && (st_r.mode == exec_pkg::MODE_RUN);
  assign sleepTake = issueTake && (issueOp == exec_pkg::OP_SLEEP);
  assign srcVal = st_r.mem[fileIdx];
  // the entry cycle is not a run cycle, so a sleep leaves the prescaler at zero
  assign runCycle = (st_r.mode == exec_pkg::MODE_RUN);

  exec_alu alu (
    .op(issueOp),
    .srcVal(srcVal),
    .accVal(st_r.acc),
    .literal(literal),
    .carryIn(st_r.stat[exec_pkg::ST_C]),
    .result(aluResult),
    .cOut(aluC),
    .dcOut(aluDc),
    .zOut(aluZ),
    .updC(updC),
    .updDc(updDc),
    .updZ(updZ),
    .fileForm(fileForm)
  );

  watchdog_clear wdog (
    .clk(clk),
    .rstn(rstn),
    .clearReq(sleepTake),
    .runEn(runCycle),
    .wdogCount(wdogCount),
    .prescCount(prescCount)
  );

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    st_nxt.rdData = exec_pkg::READ_IDLE;
    if (busRd)
    begin
      if (!busAddr[exec_pkg::ADDR_HIGH_BIT])
      begin
        st_nxt.rdData = st_r.mem[busAddr[6:0]];
      end
      else
      begin
        case (busAddr)
          exec_pkg::ADDR_ACC: st_nxt.rdData = st_r.acc;
          exec_pkg::ADDR_STATUS: st_nxt.rdData = {3'b000, st_r.stat};
          exec_pkg::ADDR_WDOG: st_nxt.rdData = wdogCount;
          exec_pkg::ADDR_PRESC: st_nxt.rdData = prescCount;
          exec_pkg::ADDR_CTRL: st_nxt.rdData = {7'h00, st_r.sleeping};
          default: st_nxt.rdData = exec_pkg::READ_IDLE;
        endcase
      end
    end
    // software writes first, so a same-cycle instruction result wins
    if (busWr)
    begin
      if (!busAddr[exec_pkg::ADDR_HIGH_BIT])
      begin
        st_nxt.mem[busAddr[6:0]] = busWrData;
      end
      else
      begin
        case (busAddr)
          exec_pkg::ADDR_ACC: st_nxt.acc = busWrData;
          exec_pkg::ADDR_STATUS: st_nxt.stat = busWrData[4:0];
          exec_pkg::ADDR_CTRL:
          begin
            if (busWrData[exec_pkg::CTRL_WAKE] && st_r.mode == exec_pkg::MODE_ASLEEP)
            begin
              st_nxt.mode = exec_pkg::MODE_RUN;
              st_nxt.oscOn = 1'b1;
              st_nxt.sleeping = 1'b0;
            end
          end
          default:
          begin
            st_nxt.stat = st_nxt.stat;
          end
        endcase
      end
    end
    case (st_r.mode)
      exec_pkg::MODE_ENTER:
      begin
        st_nxt.mode = exec_pkg::MODE_ASLEEP;
        st_nxt.oscOn = 1'b0;
        st_nxt.sleeping = 1'b1;
      end
      default:
      begin
        st_nxt.mode = st_nxt.mode;
      end
    endcase
    if (issueTake)
    begin
      st_nxt.done = 1'b1;
      if (sleepTake)
      begin
        st_nxt.stat[exec_pkg::ST_TIMEOUT] = 1'b1;
        st_nxt.stat[exec_pkg::ST_POWERDOWN] = 1'b0;
        st_nxt.mode = exec_pkg::MODE_ENTER;
      end
      else
      begin
        if (fileForm && destSel)
        begin
          st_nxt.mem[fileIdx] = aluResult;
        end
        else
        begin
          st_nxt.acc = aluResult;
        end
        if (updC)
        begin
          st_nxt.stat[exec_pkg::ST_C] = aluC;
        end
        if (updDc)
        begin
          st_nxt.stat[exec_pkg::ST_DC] = aluDc;
        end
        if (updZ)
        begin
          st_nxt.stat[exec_pkg::ST_Z] = aluZ;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r.mem <= {128{exec_pkg::FILE_RESET}};
      st_r.acc <= exec_pkg::ACC_RESET;
      st_r.stat <= exec_pkg::STATUS_RESET;
      st_r.mode <= exec_pkg::MODE_RUN;
      st_r.rdData <= exec_pkg::READ_IDLE;
      st_r.done <= 1'b0;
      st_r.oscOn <= 1'b1;
      st_r.sleeping <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign issueDone = st_r.done;
  assign busRdData = st_r.rdData;
  assign oscEnable = st_r.oscOn;
  assign asleep = st_r.sleeping;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  logic [4:0] statPast;
  assign statPast = st_r.stat;

  rot_carry_a: assert property (
    issueTake && issueOp == exec_pkg::OP_ROTATE_RIGHT_CARRY && !busWr |=>
      st_r.stat[exec_pkg::ST_C] == $past(srcVal[0])
      && st_r.stat[4:1] == $past(statPast[4:1]))
    else $error("rotate carry or flags wrong");
  dest_acc_a: assert property (
    issueTake && issueOp != exec_pkg::OP_SLEEP && !(fileForm && destSel) |=>
      st_r.acc == $past(aluResult))
    else $error("accumulator destination wrong");
  dest_file_a: assert property (
    issueTake && fileForm && destSel && !busWr |=>
      st_r.mem[$past(fileIdx)] == $past(aluResult) && $stable(st_r.acc))
    else $error("file destination wrong");
  sleep_clear_a: assert property (
    sleepTake |=> wdogCount == exec_pkg::WDOG_CLEAR && prescCount == exec_pkg::PRESC_CLEAR
      && st_r.stat[exec_pkg::ST_TIMEOUT] && !st_r.stat[exec_pkg::ST_POWERDOWN])
    else $error("sleep did not clear watchdog or flags");
  sleep_enter_a: assert property (
    sleepTake |=> oscEnable ##1 (!oscEnable && asleep))
    else $error("sleep entry sequence wrong");
  lit_sub_a: assert property (
    issueTake && issueOp == exec_pkg::OP_LITERAL_MINUS_ACC && !busWr |=>
      st_r.acc == 8'($past(literal) - $past(st_r.acc))
      && st_r.stat[exec_pkg::ST_C] == ($past(literal) >= $past(st_r.acc)))
    else $error("literal subtract wrong");
  file_sub_a: assert property (
    issueTake && issueOp == exec_pkg::OP_FILE_MINUS_ACC && !busWr |=>
      st_r.stat[exec_pkg::ST_C] == ($past(srcVal) >= $past(st_r.acc))
      && st_r.stat[exec_pkg::ST_Z] == ($past(srcVal) == $past(st_r.acc)))
    else $error("file subtract flags wrong");
  swap_a: assert property (
    issueTake && issueOp == exec_pkg::OP_NIBBLE_EXCHANGE && !busWr |=>
      $past(aluResult) == {$past(srcVal[3:0]), $past(srcVal[7:4])} && $stable(st_r.stat))
    else $error("nibble exchange wrong");
  lit_xor_a: assert property (
    issueTake && issueOp == exec_pkg::OP_LITERAL_XOR_ACC && !busWr |=>
      st_r.acc == ($past(literal) ^ $past(st_r.acc)) && st_r.stat[1:0] == $past(statPast[1:0]))
    else $error("literal xor wrong");
  file_xor_a: assert property (
    issueTake && issueOp == exec_pkg::OP_FILE_XOR_ACC && !busWr |=>
      st_r.stat[exec_pkg::ST_Z] == ($past(srcVal) == $past(st_r.acc))
      && st_r.stat[1:0] == $past(statPast[1:0]))
    else $error("file xor wrong");

  // expected values below come from the rule text, not from the alu outputs
  rot_value_a: assert property (
    issueTake && issueOp == exec_pkg::OP_ROTATE_RIGHT_CARRY && !destSel |=>
      st_r.acc == {$past(statPast[exec_pkg::ST_C]), $past(srcVal[7:1])})
    else $error("rotate value wrong");
  sub_value_a: assert property (
    issueTake && issueOp == exec_pkg::OP_FILE_MINUS_ACC && !destSel |=>
      st_r.acc == 8'($past(srcVal) - $past(st_r.acc)))
    else $error("file subtract value wrong");
  lit_half_a: assert property (
    issueTake && issueOp == exec_pkg::OP_LITERAL_MINUS_ACC && !busWr |=>
      st_r.stat[exec_pkg::ST_DC] == ($past(literal[3:0]) >= $past(st_r.acc[3:0]))
      && st_r.stat[exec_pkg::ST_Z] == ($past(literal) == $past(st_r.acc)))
    else $error("literal subtract half carry or zero wrong");
  file_half_a: assert property (
    issueTake && issueOp == exec_pkg::OP_FILE_MINUS_ACC && !busWr |=>
      st_r.stat[exec_pkg::ST_DC] == ($past(srcVal[3:0]) >= $past(st_r.acc[3:0])))
    else $error("file subtract half carry wrong");
  swap_dest_a: assert property (
    issueTake && issueOp == exec_pkg::OP_NIBBLE_EXCHANGE && destSel |=>
      st_r.mem[$past(fileIdx)] == {$past(srcVal[3:0]), $past(srcVal[7:4])})
    else $error("nibble exchange destination wrong");
  xor_dest_a: assert property (
    issueTake && issueOp == exec_pkg::OP_FILE_XOR_ACC && destSel |=>
      st_r.mem[$past(fileIdx)] == ($past(srcVal) ^ $past(st_r.acc)))
    else $error("file xor destination wrong");
  lit_keep_a: assert property (
    issueTake && (issueOp == exec_pkg::OP_LITERAL_MINUS_ACC || issueOp == exec_pkg::OP_LITERAL_XOR_ACC)
      && !busWr |=> $stable(st_r.mem))
    else $error("literal form touched a file register");
  sleep_keep_a: assert property (
    sleepTake && !busWr |=> st_r.stat[2:0] == $past(statPast[2:0]) && $stable(st_r.acc))
    else $error("sleep changed arithmetic flags or accumulator");
  refused_a: assert property (
    issueValid && st_r.mode != exec_pkg::MODE_RUN |=> !issueDone)
    else $error("instruction taken while not running");
  wdog_frozen_a: assert property (
    st_r.mode != exec_pkg::MODE_RUN |=> $stable(prescCount) && $stable(wdogCount))
    else $error("watchdog moved outside run mode");

  sleep_c: cover property (sleepTake ##2 asleep);
  borrow_c: cover property (issueTake && issueOp == exec_pkg::OP_FILE_MINUS_ACC && srcVal < st_r.acc);
  rot_file_c: cover property (issueTake && issueOp == exec_pkg::OP_ROTATE_RIGHT_CARRY && destSel);
  wake_c: cover property (asleep ##1 oscEnable);
  refuse_c: cover property (issueValid && asleep);
endmodule // exec_unit
`default_nettype wire

/* logic/exec_pkg.sv */
`default_nettype none
package exec_pkg;
  // bus map: 00..7F file registers by index
  localparam logic [7:0] ADDR_ACC = 8'h80;
  localparam logic [7:0] ADDR_STATUS = 8'h81;
  localparam logic [7:0] ADDR_WDOG = 8'h82;
  localparam logic [7:0] ADDR_PRESC = 8'h83;
  localparam logic [7:0] ADDR_CTRL = 8'h84;
  localparam int unsigned ADDR_HIGH_BIT = 7;
  // status field positions
  localparam int unsigned ST_C = 0;
  localparam int unsigned ST_DC = 1;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_POWERDOWN = 3;
  localparam int unsigned ST_TIMEOUT = 4;
  localparam int unsigned CTRL_WAKE = 0;
  // reset and clear values
  localparam logic [4:0] STATUS_RESET = 5'h18;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic [7:0] WDOG_CLEAR = 8'h00;
  localparam logic [7:0] PRESC_CLEAR = 8'h00;
  localparam logic [7:0] PRESC_LAST = 8'hFF;
  localparam logic [7:0] READ_IDLE = 8'h00;

  typedef enum logic [2:0] {
    OP_ROTATE_RIGHT_CARRY = 3'b000,
    OP_LITERAL_MINUS_ACC = 3'b001,
    OP_FILE_MINUS_ACC = 3'b010,
    OP_NIBBLE_EXCHANGE = 3'b011,
    OP_LITERAL_XOR_ACC = 3'b100,
    OP_FILE_XOR_ACC = 3'b101,
    OP_SLEEP = 3'b110
  } op_e;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_ENTER = 2'b01,
    MODE_ASLEEP = 2'b10
  } mode_e;
endpackage
`default_nettype wire

/* logic/exec_alu.sv */
`timescale 1ns/1ps
`default_nettype none
module exec_alu (
  // operands
  input wire exec_pkg::op_e op,
  input wire logic [7:0] srcVal,
  input wire logic [7:0] accVal,
  input wire logic [7:0] literal,
  input wire logic carryIn,
  // result and flags
  output logic [7:0] result,
  output logic cOut,
  output logic dcOut,
  output logic zOut,
  output logic updC,
  output logic updDc,
  output logic updZ,
  output logic fileForm
);
  logic [7:0] minuend;
  logic [8:0] diff;
  logic [4:0] nib;

  // two's complement: a + ~w + 1, carry out set means no borrow
  assign minuend = (op == exec_pkg::OP_LITERAL_MINUS_ACC) ? literal : srcVal;
  assign diff = {1'b0, minuend} + {1'b0, ~accVal} + 9'h001;
  assign nib = {1'b0, minuend[3:0]} + {1'b0, ~accVal[3:0]} + 5'h01;

  always_comb
  begin
    result = srcVal;
    cOut = carryIn;
    dcOut = 1'b0;
    updC = 1'b0;
    updDc = 1'b0;
    updZ = 1'b0;
    fileForm = 1'b0;
    case (op)
      exec_pkg::OP_ROTATE_RIGHT_CARRY:
      begin
        result = {carryIn, srcVal[7:1]};
        cOut = srcVal[0];
        updC = 1'b1;
        fileForm = 1'b1;
      end
      exec_pkg::OP_LITERAL_MINUS_ACC, exec_pkg::OP_FILE_MINUS_ACC:
      begin
        result = diff[7:0];
        cOut = diff[8];
        dcOut = nib[4];
        updC = 1'b1;
        updDc = 1'b1;
        updZ = 1'b1;
        fileForm = (op == exec_pkg::OP_FILE_MINUS_ACC);
      end
      exec_pkg::OP_NIBBLE_EXCHANGE:
      begin
        result = {srcVal[3:0], srcVal[7:4]};
        fileForm = 1'b1;
      end
      exec_pkg::OP_LITERAL_XOR_ACC:
      begin
        result = accVal ^ literal;
        updZ = 1'b1;
      end
      exec_pkg::OP_FILE_XOR_ACC:
      begin
        result = accVal ^ srcVal;
        updZ = 1'b1;
        fileForm = 1'b1;
      end
      default:
      begin
        result = accVal;
      end
    endcase
    zOut = (result == 8'h00);
  end
endmodule // exec_alu
`default_nettype wire

/* logic/watchdog_clear.sv */
`timescale 1ns/1ps
`default_nettype none
module watchdog_clear (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // control
  input wire logic clearReq,
  input wire logic runEn,
  // state
  output logic [7:0] wdogCount,
  output logic [7:0] prescCount
);
  typedef struct packed {
    logic [7:0] presc;
    logic [7:0] count;
  } wdog_s;

  wdog_s st_r;
  wdog_s st_nxt;

  // prescaler wrap is the one-cycle enable for the counter
  always_comb
  begin
    st_nxt = st_r;
    if (clearReq)
    begin
      st_nxt.presc = exec_pkg::PRESC_CLEAR;
      st_nxt.count = exec_pkg::WDOG_CLEAR;
    end
    else if (runEn)
    begin
      st_nxt.presc = st_r.presc + 8'h01;
      if (st_r.presc == exec_pkg::PRESC_LAST)
      begin
        st_nxt.count = st_r.count + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign wdogCount = st_r.count;
  assign prescCount = st_r.presc;
endmodule // watchdog_clear
`default_nettype wire

/* testbench/exec_unit_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module exec_unit_bench;
  logic clk;
  logic rstn;
  logic issueValid;
  exec_pkg::op_e issueOp;
  logic [6:0] fileIdx;
  logic destSel;
  logic [7:0] literal;
  logic issueDone;
  logic [7:0] busAddr;
  logic [7:0] busWrData;
  logic busWr;
  logic busRd;
  logic [7:0] busRdData;
  logic oscEnable;
  logic asleep;
  int errorCnt;
  int testsRun;

  exec_unit DUT (
    .clk(clk),
    .rstn(rstn),
    .issueValid(issueValid),
    .issueOp(issueOp),
    .fileIdx(fileIdx),
    .destSel(destSel),
    .literal(literal),
    .issueDone(issueDone),
    .busAddr(busAddr),
    .busWrData(busWrData),
    .busWr(busWr),
    .busRd(busRd),
    .busRdData(busRdData),
    .oscEnable(oscEnable),
    .asleep(asleep)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic complete_run();
    if (errorCnt == 0 && testsRun > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    busAddr <= a;
    busWrData <= d;
    busWr <= 1'b1;
    @(posedge clk);
    busWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    busAddr <= a;
    busRd <= 1'b1;
    @(posedge clk);
    busRd <= 1'b0;
    #1;
    chk(busRdData, exp);
  endtask

  task automatic issue(input exec_pkg::op_e op, input logic [6:0] idx, input logic d, input logic [7:0] lit,
                       input logic expDone);
    @(posedge clk);
    issueValid <= 1'b1;
    issueOp <= op;
    fileIdx <= idx;
    destSel <= d;
    literal <= lit;
    @(posedge clk);
    issueValid <= 1'b0;
    #1;
    chk({7'h00, issueDone}, {7'h00, expDone});
  endtask

  initial
  begin
    repeat (3000) @(posedge clk);
    errorCnt++;
    complete_run();
  end

  initial
  begin
    errorCnt = 0;
    testsRun = 0;
    rstn = 1'b0;
    issueValid = 1'b0;
    issueOp = exec_pkg::OP_ROTATE_RIGHT_CARRY;
    fileIdx = 7'h00;
    destSel = 1'b0;
    literal = 8'h00;
    busAddr = 8'h00;
    busWrData = 8'h00;
    busWr = 1'b0;
    busRd = 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rd(exec_pkg::ADDR_ACC, 8'h00);
    rd(exec_pkg::ADDR_STATUS, 8'h18);
    rd(exec_pkg::ADDR_WDOG, 8'h00);
    wr(exec_pkg::ADDR_WDOG, 8'h55);
    rd(exec_pkg::ADDR_WDOG, 8'h00);
    // unmapped space reads zero and ignores writes
    wr(8'h90, 8'hA5);
    rd(8'h90, 8'h00);
    // rotate: bit 0 into carry, old carry into bit 7
    wr(8'h05, 8'h81);
    issue(exec_pkg::OP_ROTATE_RIGHT_CARRY, 7'h05, 1'b1, 8'h00, 1'b1);
    rd(8'h05, 8'h40);
    rd(exec_pkg::ADDR_STATUS, 8'h19);
    issue(exec_pkg::OP_ROTATE_RIGHT_CARRY, 7'h05, 1'b0, 8'h00, 1'b1);
    rd(exec_pkg::ADDR_ACC, 8'hA0);
    rd(8'h05, 8'h40);
    rd(exec_pkg::ADDR_STATUS, 8'h18);
    // literal forms always land in the accumulator, destSel high on purpose
    issue(exec_pkg::OP_LITERAL_MINUS_ACC, 7'h05, 1'b1, 8'h05, 1'b1);
    rd(exec_pkg::ADDR_ACC, 8'h65);
    rd(exec_pkg::ADDR_STATUS, 8'h1A);
    rd(8'h05, 8'h40);
    issue(exec_pkg::OP_LITERAL_MINUS_ACC, 7'h00, 1'b0, 8'h65, 1'b1);
    rd(exec_pkg::ADDR_ACC, 8'h00);
    rd(exec_pkg::ADDR_STATUS, 8'h1F);
    // top file index
    wr(8'h7F, 8'h10);
    wr(exec_pkg::ADDR_ACC, 8'h01);
    issue(exec_pkg::OP_FILE_MINUS_ACC, 7'h7F, 1'b1, 8'h00, 1'b1);
    rd(8'h7F, 8'h0F);
    rd(exec_pkg::ADDR_ACC, 8'h01);
    rd(exec_pkg::ADDR_STATUS, 8'h19);
    issue(exec_pkg::OP_FILE_MINUS_ACC, 7'h7F, 1'b0, 8'h00, 1'b1);
    rd(exec_pkg::ADDR_ACC, 8'h0E);
    rd(exec_pkg::ADDR_STATUS, 8'h1B);
    // swap must leave every flag alone
    wr(8'h03, 8'h3C);
    wr(exec_pkg::ADDR_STATUS, 8'h1F);
    issue(exec_pkg::OP_NIBBLE_EXCHANGE, 7'h03, 1'b1, 8'h00, 1'b1);
    rd(8'h03, 8'hC3);
    issue(exec_pkg::OP_NIBBLE_EXCHANGE, 7'h03, 1'b0, 8'h00, 1'b1);
    rd(exec_pkg::ADDR_ACC, 8'h3C);
    rd(exec_pkg::ADDR_STATUS, 8'h1F);
    wr(exec_pkg::ADDR_STATUS, 8'h1B);
    issue(exec_pkg::OP_LITERAL_XOR_ACC, 7'h00, 1'b1, 8'h3C, 1'b1);
    rd(exec_pkg::ADDR_ACC, 8'h00);
    rd(exec_pkg::ADDR_STATUS, 8'h1F);
    issue(exec_pkg::OP_LITERAL_XOR_ACC, 7'h00, 1'b0, 8'hFF, 1'b1);
    rd(exec_pkg::ADDR_ACC, 8'hFF);
    rd(exec_pkg::ADDR_STATUS, 8'h1B);
    wr(8'h09, 8'h0F);
    issue(exec_pkg::OP_FILE_XOR_ACC, 7'h09, 1'b1, 8'h00, 1'b1);
    rd(8'h09, 8'hF0);
    rd(exec_pkg::ADDR_ACC, 8'hFF);
    issue(exec_pkg::OP_FILE_XOR_ACC, 7'h09, 1'b0, 8'h00, 1'b1);
    rd(exec_pkg::ADDR_ACC, 8'h0F);
    wr(exec_pkg::ADDR_ACC, 8'hF0);
    issue(exec_pkg::OP_FILE_XOR_ACC, 7'h09, 1'b0, 8'h00, 1'b1);
    rd(exec_pkg::ADDR_STATUS, 8'h1F);
    // let the watchdog step at least once so that the sleep clear is visible
    repeat (300) @(posedge clk);
    // sleep from a state with timeout clear and power-down set
    wr(exec_pkg::ADDR_STATUS, 8'h08);
    issue(exec_pkg::OP_SLEEP, 7'h00, 1'b0, 8'h00, 1'b1);
    chk({7'h00, oscEnable}, 8'h01);
    @(posedge clk);
    #1;
    chk({6'h00, oscEnable, asleep}, 8'h01);
    rd(exec_pkg::ADDR_STATUS, 8'h10);
    rd(exec_pkg::ADDR_WDOG, 8'h00);
    rd(exec_pkg::ADDR_PRESC, 8'h00);
    rd(exec_pkg::ADDR_CTRL, 8'h01);
    // instructions are refused while the oscillator is stopped
    issue(exec_pkg::OP_LITERAL_XOR_ACC, 7'h00, 1'b0, 8'hFF, 1'b0);
    rd(exec_pkg::ADDR_ACC, 8'h00);
    rd(exec_pkg::ADDR_PRESC, 8'h00);
    wr(exec_pkg::ADDR_CTRL, 8'h01);
    #1;
    chk({6'h00, oscEnable, asleep}, 8'h02);
    issue(exec_pkg::OP_LITERAL_XOR_ACC, 7'h00, 1'b0, 8'h5A, 1'b1);
    rd(exec_pkg::ADDR_ACC, 8'h5A);
    complete_run();
  end
endmodule // exec_unit_bench
`default_nettype wire
